// File: verilog/i2c_engine_pkg.sv
// Constants, register map and carrier types of the I2C leader transfer engine.
// Assumes a 25 MHz core clock and an Avalon-MM slave port with byte addresses.
// Overview of operation
// [RULE1] Nonzero read switch count: repeated start after that many bytes, then read.
// [RULE2] Zero read switch count: whole transfer written, no repeated start.
// [RULE3] Final stop request set: stop after last byte; clear: no stop.
// [RULE4] While a transaction is open without stop, hold clock low, report held.
// [RULE5] Nonzero start count begins a transfer of that many bytes, address included.
// [RULE6] Start count above 36 is treated as 36.
// [RULE7] Status reports bytes transferred before a not-acknowledge; zero at reset.
// [RULE8] A driven data bit read back different sets the mismatch flag; the code flags only a released one bit read back low.
// [RULE9] A not-acknowledge from the target sets the not-acknowledged flag.
// [RULE10] Bus held bit reads zero when no transaction is open.
// [RULE11] In-execution bit is one while a transfer runs, zero when done.
// [RULE12] Host leaves the data buffer alone while in execution.
// [RULE13] Reserved bits of control and status read zero.
// [RULE14] All control and status fields reset to zero.
// [RULE15] Clearing the enable during a transaction sends a stop, releases the bus.
// [RULE16] Two-bit rate select: 100 kHz, 400 kHz, 1000 kHz, 11 reserved.
// [RULE17] Host puts target address in first buffer byte, subaddress next.
// [RULE18] Bytes sent in ascending order; received bytes stored in following positions.
// [RULE19] Host keeps read switch count below the transfer byte count.
package i2c_engine_pkg;

   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_CFG       = 12'hC00;
   localparam logic [11:0] IDX_CTRL      = 12'hC01;
   localparam logic [11:0] IDX_STAT      = 12'hC02;
   localparam logic [11:0] IDX_DATA0     = 12'hC04;
   localparam logic [11:0] IDX_IRQ_STAT  = 12'hC20;
   localparam logic [11:0] IDX_IRQ_MASK  = 12'hC21;
   localparam int          DATA_REGS     = 18;

   // Field positions
   localparam int CFG_EN_BIT     = 0;
   localparam int CFG_RATE_LSB   = 1;
   localparam int CTRL_START_LSB = 0;
   localparam int CTRL_STOP_BIT  = 6;
   localparam int CTRL_RDSW_LSB  = 8;
   localparam int STAT_PEND_BIT  = 0;
   localparam int STAT_HELD_BIT  = 1;
   localparam int STAT_NACK_BIT  = 2;
   localparam int STAT_MISM_BIT  = 3;
   localparam int STAT_LEN_LSB   = 8;
   localparam int IRQ_DONE_BIT   = 0;
   localparam int IRQ_NACK_BIT   = 1;
   localparam int IRQ_MISM_BIT   = 2;
   localparam int IRQ_W          = 3;

   localparam logic [5:0] MAX_BYTES  = 6'h24;
   localparam logic [5:0] COUNT_ZERO = 6'h00;
   localparam logic [5:0] COUNT_ONE  = 6'h01;
   localparam logic [7:0] READ_BIT   = 8'h01;

   // Bus rate selection and quarter bit times, rounded up
   localparam int          CLOCK_HZ  = 25_000_000;
   localparam int          RATE0_HZ  = 100_000;
   localparam int          RATE1_HZ  = 400_000;
   localparam int          RATE2_HZ  = 1_000_000;
   localparam logic [1:0]  RATE_SEL1 = 2'h1;
   localparam logic [1:0]  RATE_SEL2 = 2'h2;
   localparam logic [7:0]  QUARTER0  = 8'((CLOCK_HZ + 4 * RATE0_HZ - 1) / (4 * RATE0_HZ));
   localparam logic [7:0]  QUARTER1  = 8'((CLOCK_HZ + 4 * RATE1_HZ - 1) / (4 * RATE1_HZ));
   localparam logic [7:0]  QUARTER2  = 8'((CLOCK_HZ + 4 * RATE2_HZ - 1) / (4 * RATE2_HZ));

   typedef struct packed {
      logic [5:0] read_switch_count;
      logic       final_stop_request;
      logic [5:0] start_count;
   } ctrl_type;

   typedef struct packed {
      logic       enable;
      logic [1:0] bus_rate_select;
   } cfg_type;

endpackage

// File: verilog/i2c_leader_transfer_engine.sv
// I2C leader transfer engine with its register file and interrupt logic.
// Assumes open-drain pads outside; SCL and SDA inputs are asynchronous.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module i2c_leader_transfer_engine
   import i2c_engine_pkg::*;
#(
   parameter int BUF_BYTES = 36
) (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic [13:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic             irq_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o
);

   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_HOLD, ST_STOP} state_type;

   // Quarter bit time for a rate select
   function automatic logic [7:0] quarter_of(input logic [1:0] sel);
      return (sel == RATE_SEL1) ? QUARTER1 : ((sel == RATE_SEL2) ? QUARTER2 : QUARTER0);
   endfunction

   state_type           state_r;
   cfg_type             cfg_r;
   ctrl_type            ctrl_r;
   logic [1:0]          phase_r;
   logic [7:0]          qcnt_r;
   logic [2:0]          bit_r;
   logic [5:0]          byte_idx_r, len_r, acked_byte_count_r;
   logic [7:0]          shift_r;
   logic                reading_r, addr_again_r, restart_r;
   logic                not_acknowledged_flag_r;
   logic                data_bit_mismatch_flag_r;
   logic                ev_done_r, ev_nack_r, ev_mism_r;
   logic [IRQ_W-1:0]    irq_stat_r, irq_mask_r;
   logic [7:0]          buf_r [BUF_BYTES];
   logic                ack_r;
   logic [31:0]         readdata_r;
   logic                scl_m_r, scl_s_r, sda_m_r, sda_s_r;
   logic                scl_low_r, sda_low_r;
   logic                scl_low_nxt, sda_low_nxt;
   logic [11:0]         idx, data_k;
   logic                data_hit, wr_go;
   logic [15:0]         stat_word;
   logic [31:0]         read_mux;
   logic                start_go, pending, reading_eff, qtick, slot_end;
   logic [5:0]          next_idx, start_len;
   logic [IRQ_W-1:0]    irq_events;

   // Two-flop synchronisers on the bus lines
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
      end else begin
         scl_m_r <= scl_i;
         scl_s_r <= scl_m_r;
         sda_m_r <= sda_i;
         sda_s_r <= sda_m_r;
      end
   end

   // Avalon decode; one wait state on every access
   assign idx               = avs_address_i[13:2];
   assign data_k            = idx - IDX_DATA0;
   assign data_hit          = (idx >= IDX_DATA0) && (data_k < 12'(DATA_REGS));
   assign wr_go             = avs_write_i && ack_r;
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
   assign avs_readdata_o    = readdata_r;

   // Engine status views
   assign pending     = (state_r != ST_IDLE) && (state_r != ST_HOLD); // RULE11
   assign reading_eff = reading_r && !addr_again_r;
   assign next_idx    = 6'(byte_idx_r + COUNT_ONE);
   assign start_len   = (avs_writedata_i[5:0] > MAX_BYTES) ? MAX_BYTES
                                                           : avs_writedata_i[5:0]; // RULE6
   assign start_go    = wr_go && idx == IDX_CTRL && avs_byteenable_i[0] && !pending
                        && cfg_r.enable && avs_writedata_i[5:0] != COUNT_ZERO; // RULE5

   // Status word; reserved bits stay zero
   always_comb begin
      stat_word = '0; // RULE13
      stat_word[STAT_PEND_BIT] = pending; // RULE11
      stat_word[STAT_HELD_BIT] = (state_r != ST_IDLE); // RULE4 RULE10
      stat_word[STAT_NACK_BIT] = not_acknowledged_flag_r;
      stat_word[STAT_MISM_BIT] = data_bit_mismatch_flag_r;
      stat_word[STAT_LEN_LSB +: 6] = acked_byte_count_r; // RULE7
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      read_mux = '0;
      if (idx == IDX_CFG) begin
         read_mux[CFG_EN_BIT]        = cfg_r.enable;
         read_mux[CFG_RATE_LSB +: 2] = cfg_r.bus_rate_select;
      end else if (idx == IDX_CTRL) begin
         read_mux[CTRL_START_LSB +: 6] = ctrl_r.start_count; // RULE13
         read_mux[CTRL_STOP_BIT]       = ctrl_r.final_stop_request;
         read_mux[CTRL_RDSW_LSB +: 6]  = ctrl_r.read_switch_count;
      end else if (idx == IDX_STAT) begin
         read_mux[15:0] = stat_word;
      end else if (idx == IDX_IRQ_STAT) begin
         read_mux[IRQ_W-1:0] = irq_stat_r;
      end else if (idx == IDX_IRQ_MASK) begin
         read_mux[IRQ_W-1:0] = irq_mask_r;
      end else if (data_hit) begin
         read_mux[15:0] = {buf_r[6'(2 * data_k + 1)], buf_r[6'(2 * data_k)]};
      end
   end

   // Bus handshake and read data capture
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ack_r      <= 1'b0;
         readdata_r <= '0;
      end else begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
         if (avs_read_i && !ack_r) begin
            readdata_r <= read_mux;
         end
      end
   end

   // Configuration and control registers; control frozen while in execution
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cfg_r  <= '0; // RULE14
         ctrl_r <= '0;
      end else begin
         if (wr_go && idx == IDX_CFG && avs_byteenable_i[0]) begin
            cfg_r.enable          <= avs_writedata_i[CFG_EN_BIT];
            cfg_r.bus_rate_select <= avs_writedata_i[CFG_RATE_LSB +: 2]; // RULE16
         end
         if (wr_go && idx == IDX_CTRL && !pending) begin
            if (avs_byteenable_i[0]) begin
               ctrl_r.start_count        <= avs_writedata_i[CTRL_START_LSB +: 6];
               ctrl_r.final_stop_request <= avs_writedata_i[CTRL_STOP_BIT]; // RULE3
            end
            if (avs_byteenable_i[1]) begin
               ctrl_r.read_switch_count <= avs_writedata_i[CTRL_RDSW_LSB +: 6];
            end
         end
      end
   end

   // Byte buffer: host writes when not in execution, engine stores received bytes
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         for (int i = 0; i < BUF_BYTES; i++) begin
            buf_r[i] <= '0;
         end
      end else if (state_r == ST_ACK && slot_end && reading_eff) begin
         buf_r[byte_idx_r] <= shift_r; // RULE18
      end else if (wr_go && data_hit && !pending) begin // RULE12
         if (avs_byteenable_i[0]) begin
            buf_r[6'(2 * data_k)] <= avs_writedata_i[7:0]; // RULE17
         end
         if (avs_byteenable_i[1]) begin
            buf_r[6'(2 * data_k + 1)] <= avs_writedata_i[15:8];
         end
      end
   end

   // Quarter-bit timer; a target stretching SCL freezes the high half
   assign qtick    = (qcnt_r == '0) && !(phase_r[1] && !scl_low_r && !scl_s_r);
   assign slot_end = qtick && (phase_r == 2'h3);

   always_ff @(posedge clock_i) begin
      if (rst_i || start_go || state_r == ST_IDLE || (!cfg_r.enable && state_r != ST_STOP)) begin
         qcnt_r  <= '0;
         phase_r <= '0;
      end else if (qtick) begin
         qcnt_r  <= 8'(quarter_of(cfg_r.bus_rate_select) - 8'h01); // RULE16
         phase_r <= 2'(phase_r + 2'h1);
      end else if (qcnt_r != '0) begin
         qcnt_r <= 8'(qcnt_r - 8'h01);
      end
   end

   // Transfer sequencer
   always_ff @(posedge clock_i) begin
      ev_done_r <= 1'b0;
      ev_nack_r <= 1'b0;
      ev_mism_r <= 1'b0;
      if (rst_i) begin
         state_r                  <= ST_IDLE;
         bit_r                    <= '0;
         byte_idx_r               <= '0;
         len_r                    <= '0;
         acked_byte_count_r       <= '0; // RULE14
         shift_r                  <= '0;
         reading_r                <= 1'b0;
         addr_again_r             <= 1'b0;
         restart_r                <= 1'b0;
         not_acknowledged_flag_r  <= 1'b0;
         data_bit_mismatch_flag_r <= 1'b0;
      end else if (!cfg_r.enable && state_r != ST_IDLE && state_r != ST_STOP) begin
         state_r <= ST_STOP; // RULE15
      end else if (start_go) begin
         state_r                  <= ST_START;
         restart_r                <= (state_r == ST_HOLD);
         len_r                    <= start_len; // RULE5 RULE6
         byte_idx_r               <= '0;
         acked_byte_count_r       <= '0; // RULE7
         reading_r                <= 1'b0;
         addr_again_r             <= 1'b0;
         not_acknowledged_flag_r  <= 1'b0;
         data_bit_mismatch_flag_r <= 1'b0;
      end else if (slot_end) begin
         unique case (state_r)
            ST_START: begin
               state_r <= ST_BIT;
               bit_r   <= 3'h7;
               shift_r <= addr_again_r ? (buf_r[0] | READ_BIT) : buf_r[byte_idx_r];
            end
            ST_BIT: begin
               if (!reading_eff && shift_r[7] && !sda_s_r) begin
                  data_bit_mismatch_flag_r <= 1'b1; // RULE8
                  ev_mism_r                <= 1'b1;
                  state_r                  <= ST_IDLE;
               end else begin
                  shift_r <= {shift_r[6:0], sda_s_r};
                  bit_r   <= 3'(bit_r - 3'h1);
                  if (bit_r == '0) begin
                     state_r <= ST_ACK;
                  end
               end
            end
            ST_ACK: begin
               bit_r <= 3'h7;
               if (!reading_eff && sda_s_r) begin
                  not_acknowledged_flag_r <= 1'b1; // RULE9
                  ev_nack_r               <= 1'b1;
                  state_r                 <= ST_STOP;
               end else if (addr_again_r) begin
                  addr_again_r <= 1'b0;
                  state_r      <= ST_BIT;
               end else begin
                  byte_idx_r         <= next_idx;
                  acked_byte_count_r <= next_idx; // RULE7
                  shift_r            <= buf_r[next_idx]; // RULE18
                  if (next_idx == len_r) begin
                     ev_done_r <= 1'b1;
                     state_r   <= ctrl_r.final_stop_request ? ST_STOP : ST_HOLD; // RULE3 RULE4
                  end else if (!reading_r && next_idx == ctrl_r.read_switch_count) begin
                     state_r      <= ST_START; // RULE1 RULE2
                     restart_r    <= 1'b1;
                     reading_r    <= 1'b1;
                     addr_again_r <= 1'b1;
                  end else begin
                     state_r <= ST_BIT;
                  end
               end
            end
            ST_STOP: state_r <= ST_IDLE; // RULE10
            ST_HOLD, ST_IDLE: state_r <= state_r;
         endcase
      end
   end

   // Line drive per slot quarter; SDA moves only while SCL is low, except for start and stop
   always_comb begin
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
      unique case (state_r)
         ST_IDLE: scl_low_nxt = 1'b0;
         ST_START: begin
            scl_low_nxt = (phase_r == 2'h0) && restart_r;
            sda_low_nxt = phase_r[1];
         end
         ST_BIT: begin
            scl_low_nxt = !phase_r[1];
            sda_low_nxt = (phase_r == 2'h0) ? sda_low_r : (!reading_eff && !shift_r[7]);
         end
         ST_ACK: begin
            scl_low_nxt = !phase_r[1];
            sda_low_nxt = (phase_r == 2'h0) ? sda_low_r : (reading_eff && next_idx != len_r);
         end
         ST_HOLD: begin
            scl_low_nxt = 1'b1; // RULE4
            sda_low_nxt = sda_low_r;
         end
         ST_STOP: begin
            scl_low_nxt = !phase_r[1];
            sda_low_nxt = (phase_r == 2'h0) ? sda_low_r : (phase_r != 2'h3); // RULE15
         end
      endcase
   end

   // Registered open-drain enables
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
      end else begin
         scl_low_r <= scl_low_nxt;
         sda_low_r <= sda_low_nxt;
      end
   end

   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe_o = scl_low_r;
   assign sda_oe_o = sda_low_r;

   // Interrupt status, write one to clear, set wins over clear
   assign irq_events = {ev_mism_r, ev_nack_r, ev_done_r};

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
      end else begin
         if (wr_go && idx == IDX_IRQ_MASK && avs_byteenable_i[0]) begin
            irq_mask_r <= avs_writedata_i[IRQ_W-1:0];
         end
         if (wr_go && idx == IDX_IRQ_STAT && avs_byteenable_i[0]) begin
            irq_stat_r <= (irq_stat_r & ~avs_writedata_i[IRQ_W-1:0]) | irq_events;
         end else begin
            irq_stat_r <= irq_stat_r | irq_events;
         end
      end
   end

   assign irq_o = |(irq_stat_r & irq_mask_r);

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   hold_scl_low_a: assert property ((state_r == ST_HOLD) |=> scl_oe_o) // RULE4
      else $error("clock line not held low in open transaction");
   held_bit_a: assert property (!stat_word[STAT_HELD_BIT] |=> !scl_oe_o && !sda_oe_o) // RULE10
      else $error("bus driven while no transaction is open");
   start_pending_a: assert property (start_go |=> stat_word[STAT_PEND_BIT] ##1 pending) // RULE11
      else $error("start did not raise in-execution");
   len_clamp_a: assert property (start_go |=> (len_r <= MAX_BYTES && len_r != COUNT_ZERO)) // RULE6
      else $error("transfer length out of range");
   no_read_switch_a: assert property ((pending && reading_r) |-> ctrl_r.read_switch_count != COUNT_ZERO) // RULE2
      else $error("read switch without a read count");
   hold_no_stop_a: assert property ($rose(state_r == ST_HOLD) |-> !ctrl_r.final_stop_request) // RULE3
      else $error("held bus although stop was requested");
   reserved_zero_a: assert property (stat_word[7:4] == '0 && stat_word[15:14] == '0) // RULE13
      else $error("reserved status bits not zero");
   nack_flag_a: assert property (ev_nack_r |-> not_acknowledged_flag_r ##1 state_r == ST_STOP) // RULE9
      else $error("not-acknowledge not flagged");
   mismatch_a: assert property ((state_r == ST_BIT && slot_end && !reading_eff && shift_r[7]
      && !sda_s_r && cfg_r.enable) |=> data_bit_mismatch_flag_r && state_r == ST_IDLE) // RULE8
      else $error("data bit mismatch not flagged");
   disable_stop_a: assert property ((!cfg_r.enable && state_r inside {ST_BIT, ST_ACK, ST_HOLD})
      |=> state_r == ST_STOP) // RULE15
      else $error("disable did not send a stop");
   count_clear_a: assert property (start_go |=> acked_byte_count_r == COUNT_ZERO) // RULE7
      else $error("acked byte count not cleared at start");
   bus_answer_a: assert property ((avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
      else $error("bus access not answered in one wait state");

endmodule

// File: verif/i2c_target_model.sv
// Behavioural I2C target: acks written bytes, answers reads with one fixed byte.
// Assumes open-drain lines resolved by the bench with pull-ups.
`timescale 1ns/10ps
module i2c_target_model (
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic       nack_i,
   input  wire logic       jam_i,
   input  wire logic [7:0] rd_byte_i,
   output logic            sda_pull_o,
   output logic [7:0]      last_byte_o,
   output logic [7:0]      starts_o
);
   int         bcnt = 99;
   logic       first, reading, mack;
   logic       drv  = 1'b0;
   logic       pull = 1'b0;
   logic [7:0] sh;
   initial starts_o = 8'h00;
   // Jam holds data low to provoke a data bit mismatch
   assign sda_pull_o = pull | jam_i;
   // Start or repeated start while clock is high
   always @(negedge sda_i) begin
      if (scl_i) begin
         bcnt = -1;
         first = 1'b1;
         reading = 1'b0;
         drv = 1'b0;
         pull = 1'b0;
         starts_o = starts_o + 8'h01;
      end
   end
   // Stop while clock is high
   always @(posedge sda_i) begin
      if (scl_i) begin
         bcnt = 99;
         pull = 1'b0;
      end
   end
   // Bits shift in on clock rise; the ninth is the leader's ack
   always @(posedge scl_i) begin
      if (bcnt >= 0 && bcnt < 8)
         sh = {sh[6:0], sda_i};
      else if (bcnt == 8)
         mack = ~sda_i;
   end
   // Data and ack change only while the clock is low
   always @(negedge scl_i) begin
      if (bcnt < 99) begin
         bcnt = bcnt + 1;
         if (bcnt == 9) begin
            bcnt = 0;
            last_byte_o = sh;
            drv = first ? sh[0] : reading & mack;
            reading = reading | (first & sh[0]);
            first = 1'b0;
         end
         pull = (bcnt == 8) ? (~reading & ~nack_i) : (drv && bcnt < 8 && !rd_byte_i[7 - bcnt]);
      end
   end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the I2C leader transfer engine.
// Assumes the target model on pulled-up lines and a 25 MHz core clock.
`timescale 1ns/10ps
module testbench;
   import i2c_engine_pkg::*;
   logic        clock_i, rst_i, avs_read_i, avs_write_i, nack, jam, pull;
   logic [13:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic        avs_waitrequest_o, irq_o, scl_oe_o, sda_oe_o;
   logic [7:0]  last_byte, starts, s0;
   int          miscompares = 0;
   int          n_tests = 0;
   int          cycles = 0;
   wire         scl_line = ~scl_oe_o;
   wire         sda_line = ~(sda_oe_o | pull);

   i2c_leader_transfer_engine u_i2c_leader_transfer_engine (
      .clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .irq_o(irq_o), .scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe_o),
      .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe_o));

   i2c_target_model u_i2c_target_model (
      .scl_i(scl_line), .sda_i(sda_line), .nack_i(nack), .jam_i(jam),
      .rd_byte_i(8'h3C), .sda_pull_o(pull), .last_byte_o(last_byte), .starts_o(starts));

   // Core clock, 40 ns period
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   // Hang guard
   always @(posedge clock_i) begin
      cycles = cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         complete_run;
      end
   end

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [15:0] d);
      @(posedge clock_i);
      avs_address_i   <= {idx, 2'b00};
      avs_writedata_i <= {16'h0000, d};
      avs_write_i     <= wr;
      avs_read_i      <= ~wr;
      do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] idx, input logic [15:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 16'h0000);
      check(rd, exp);
   endtask

   // Poll status until the masked bits are clear; only status is touched
   task automatic wait_clear(input logic [15:0] m);
      do bus(1'b0, IDX_STAT, 16'h0000); while ((rd[15:0] & m) != 16'h0000);
   endtask

   // Clock-line period inside a byte is four quarter bit times
   task automatic t_period(input int q);
      int n;
      @(negedge scl_line);
      n = cycles;
      @(negedge scl_line);
      check(cycles - n, 4 * q);
   endtask

   task automatic t_reset;
      rdchk(IDX_CTRL, 32'h0000_0000);
      rdchk(IDX_STAT, 32'h0000_0000);
      rdchk(IDX_CFG, 32'h0000_0000);
      rdchk(12'hC30, 32'h0000_0000);
      check({31'h0, irq_o}, 32'h0);
   endtask

   // Interface disabled: fields stored, reserved bits read zero
   task automatic t_reserved;
      wr(IDX_CTRL, 16'hFFFF);
      rdchk(IDX_CTRL, 32'h0000_3F7F);
      rdchk(IDX_STAT, 32'h0000_0000);
      wr(IDX_CTRL, 16'h0000);
   endtask

   task automatic t_write;
      wr(IDX_CFG, 16'h0005);
      wr(IDX_IRQ_MASK, 16'h0001);
      wr(IDX_DATA0, 16'h5AA0);
      s0 = starts;
      wr(IDX_CTRL, 16'h0042);
      t_period(QUARTER2);
      rdchk(IDX_STAT, 32'h0000_0003);
      wait_clear(16'h0001);
      rdchk(IDX_STAT, 32'h0000_0200);
      check(last_byte, 8'h5A);
      check(starts - s0, 8'h01);
      @(negedge clock_i);
      check({31'h0, scl_oe_o}, 32'h0);
      check({31'h0, irq_o}, 32'h1);
      wr(IDX_IRQ_STAT, 16'h0001);
      @(negedge clock_i);
      check({31'h0, irq_o}, 32'h0);
   endtask

   // No final stop: bus held, then released by disabling
   task automatic t_hold;
      wr(IDX_IRQ_MASK, 16'h0000);
      wr(IDX_CTRL, 16'h0001);
      wait_clear(16'h0001);
      rdchk(IDX_STAT, 32'h0000_0102);
      @(negedge clock_i);
      check({31'h0, scl_oe_o}, 32'h1);
      check({31'h0, irq_o}, 32'h0);
      rdchk(IDX_IRQ_STAT, 32'h0000_0001);
      wr(IDX_IRQ_STAT, 16'h0001);
      wr(IDX_CFG, 16'h0004);
      wait_clear(16'h0002);
      repeat (40) @(posedge clock_i);
      check({30'h0, scl_line, sda_line}, 32'h3);
      wr(IDX_CFG, 16'h0005);
   endtask

   task automatic t_rdswitch;
      wr(IDX_CFG, 16'h0003);
      wr(IDX_DATA0, 16'h10A0);
      s0 = starts;
      wr(IDX_CTRL, 16'h0243);
      t_period(QUARTER1);
      wait_clear(16'h0001);
      rdchk(12'hC05, 32'h0000_003C);
      check(starts - s0, 8'h02);
   endtask

   task automatic t_fault(input logic j, input logic [31:0] exp);
      nack = ~j;
      jam  = j;
      wr(IDX_IRQ_STAT, 16'h0007);
      wr(IDX_CTRL, 16'h0042);
      if (!j) begin
         t_period(QUARTER0);
      end
      wait_clear(16'h0001);
      rdchk(IDX_STAT, exp);
      rdchk(IDX_IRQ_STAT, {29'h0, j, ~j, 1'b0});
      nack = 1'b0;
      jam  = 1'b0;
   endtask

   initial begin
      rst_i = 1'b1;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 14'h0000;
      avs_writedata_i = 32'h0000_0000;
      nack = 1'b0;
      jam = 1'b0;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset;
      t_reserved;
      t_write;
      t_hold;
      t_rdswitch;
      wr(IDX_CFG, 16'h0001);
      t_fault(1'b0, 32'h0000_0004);
      t_fault(1'b1, 32'h0000_0008);
      wr(IDX_CFG, 16'h0005);
      wr(IDX_DATA0, 16'h00A0);
      wr(IDX_CTRL, 16'h0065);
      wait_clear(16'h0001);
      rdchk(IDX_STAT, 32'h0000_2400);
      complete_run;
   end
endmodule
